/* File: common/ipr_pkg.sv */
// shared constants, source tables and carrier types of the priority resolver
package ipr_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int NSRC = 28;
  localparam int NREG = 6;
  localparam int LVL_W = 5;
  localparam int PRIO_W = 4;
  localparam int CODE_W = 12;
  localparam int SRC_W = 5;
  localparam int REG_W = 16;
  localparam int RSEL_W = 3;
  localparam int FSEL_W = 2;
  localparam int NPERI = 17;
  localparam int NIRQ = 6;
  localparam int NPINT = 16;
  localparam int IRL_W = 4;
  localparam int PORT_PIN_INTERRUPT_GRP = 8;

  // ---------------------------------------------------------------
  // levels and fixed codes
  // ---------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_NMI = 5'h10;
  localparam logic [LVL_W-1:0] LVL_DBG = 5'h0f;
  localparam logic [LVL_W-1:0] LVL_MASKED = 5'h00;
  localparam logic [IRL_W-1:0] IRL_NONE = 4'hf;
  localparam logic [CODE_W-1:0] CODE_IRL_BASE = 12'h200;
  localparam int CODE_STEP_SHIFT = 5;
  localparam logic [REG_W-1:0] PRIO_RST = 16'h0000;

  // ---------------------------------------------------------------
  // source indices, in default tie-break order (0 wins)
  // ---------------------------------------------------------------
  localparam int SRC_NMI = 0;
  localparam int SRC_DBG = 1;
  localparam int SRC_IRL = 2;
  localparam int SRC_EXT_REQUEST_PIN_0 = 3;
  localparam int SRC_PORT_PIN_INTERRUPT_LO = 9;
  localparam int SRC_PORT_PIN_INTERRUPT_HI = 10;
  localparam int SRC_PERI0 = 11;

  // setting register indices
  localparam logic [RSEL_W-1:0] REG_C = 3'h0;
  localparam logic [RSEL_W-1:0] REG_D = 3'h1;
  localparam logic [RSEL_W-1:0] REG_E = 3'h2;
  localparam logic [RSEL_W-1:0] REG_F = 3'h3;
  localparam logic [RSEL_W-1:0] REG_G = 3'h4;
  localparam logic [RSEL_W-1:0] REG_H = 3'h5;

  // event code per source
  localparam logic [CODE_W-1:0] SRC_CODE [NSRC] = '{
    12'h1c0, 12'h5e0, 12'h200,
    12'h600, 12'h620, 12'h640, 12'h660, 12'h680, 12'h6a0,
    12'h700, 12'h720,
    12'h800, 12'h820, 12'h840, 12'h860,
    12'h880, 12'h8a0, 12'h8e0,
    12'h900, 12'h920, 12'h960,
    12'h980, 12'ha20, 12'ha40,
    12'hc00, 12'hc20, 12'hc80, 12'hca0};

  // setting register and field (0 = bits 3..0 ... 3 = bits 15..12)
  localparam logic [RSEL_W-1:0] SRC_REG [NSRC] = '{
    REG_C, REG_C, REG_C,
    REG_C, REG_C, REG_C, REG_C, REG_D, REG_D,
    REG_D, REG_D,
    REG_E, REG_E, REG_E, REG_E,
    REG_E, REG_E, REG_E,
    REG_E, REG_E, REG_E,
    REG_E, REG_F, REG_F,
    REG_G, REG_G, REG_H, REG_H};
  localparam logic [FSEL_W-1:0] SRC_FLD [NSRC] = '{
    2'h0, 2'h0, 2'h0,
    2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1,
    2'h3, 2'h2,
    2'h3, 2'h3, 2'h3, 2'h3,
    2'h2, 2'h2, 2'h2,
    2'h1, 2'h1, 2'h1,
    2'h0, 2'h1, 2'h1,
    2'h3, 2'h2, 2'h3, 2'h2};

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic [LVL_W-1:0] level;
    logic [SRC_W-1:0] src;
    logic [CODE_W-1:0] code;
  } ipr_cand_t;

  typedef struct packed {
    logic en;
    logic [RSEL_W-1:0] sel;
    logic [REG_W-1:0] data;
  } ipr_prio_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFFER = 2'b01,
    ST_TAKEN = 2'b11
  } ipr_state_t;

endpackage : ipr_pkg

/* File: rtl/ipr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module ipr_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // meta_ff feeds sync_ff only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : ipr_sync

/* File: rtl/ipr_arb.sv */
// combinational highest-level pick with fixed index tie-break
`timescale 1ns/1ns
module ipr_arb #(
  parameter int N = ipr_pkg::NSRC
) (
  input wire logic [N-1:0] i_req,
  input wire logic [N-1:0][ipr_pkg::LVL_W-1:0] i_level,
  output logic o_valid,
  output logic [ipr_pkg::SRC_W-1:0] o_idx,
  output logic [ipr_pkg::LVL_W-1:0] o_level
);

  always_comb begin
    o_valid = 1'b0;
    o_idx = '0;
    o_level = ipr_pkg::LVL_MASKED;
    for (int i = 0; i < N; i++) begin
      if (i_req[i] && (i_level[i] != ipr_pkg::LVL_MASKED) && (i_level[i] > o_level)) begin
        o_valid = 1'b1;
        o_idx = ipr_pkg::SRC_W'(i);
        o_level = i_level[i];
      end
    end
  end

endmodule : ipr_arb

/* File: rtl/ipr_top.sv */
// interrupt priority resolver: source ranking and event code latching
`timescale 1ns/1ns
module ipr_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_nmi,
  input wire logic i_dbg_req,
  input wire logic [ipr_pkg::IRL_W-1:0] i_irl_n,
  input wire logic [ipr_pkg::NIRQ-1:0] i_irq,
  input wire logic [ipr_pkg::NPINT-1:0] i_port_pin_interrupt,
  input wire logic [ipr_pkg::NPERI-1:0] i_periph,
  input wire ipr_pkg::ipr_prio_wr_t i_prio_wr,
  input wire logic [ipr_pkg::RSEL_W-1:0] i_prio_rd_sel,
  input wire logic i_core_ack,
  output logic o_int_req,
  output logic [ipr_pkg::LVL_W-1:0] o_int_level,
  output logic [ipr_pkg::SRC_W-1:0] o_int_src,
  output logic [ipr_pkg::CODE_W-1:0] o_evt_a,
  output logic [ipr_pkg::CODE_W-1:0] o_evt_b,
  output logic o_accept,
  output logic [ipr_pkg::REG_W-1:0] o_prio_rd_data
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = 1 + ipr_pkg::IRL_W + ipr_pkg::NIRQ + ipr_pkg::NPINT;

  logic [PIN_W-1:0] pins_s;
  logic nmi_s;
  logic [ipr_pkg::IRL_W-1:0] irl_inv_s;
  logic [ipr_pkg::IRL_W-1:0] irl_s;
  logic [ipr_pkg::NIRQ-1:0] irq_s;
  logic [ipr_pkg::NPINT-1:0] port_pin_interrupt_s;

  // encoded pins idle high: inverted through the synchroniser so that
  // its cleared reset state reads as idle, not as a level-15 request
  ipr_sync #(
    .W(PIN_W)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_nmi, ~i_irl_n, i_irq, i_port_pin_interrupt}),
    .o_sync(pins_s)
  );

  assign {nmi_s, irl_inv_s, irq_s, port_pin_interrupt_s} = pins_s;
  assign irl_s = ~irl_inv_s;

  // ---------------------------------------------------------------
  // state and shared declarations
  // ---------------------------------------------------------------
  ipr_pkg::ipr_state_t state_ff;
  ipr_pkg::ipr_state_t nxt_state;
  ipr_pkg::ipr_cand_t cand_ff;
  ipr_pkg::ipr_cand_t nxt_cand;
  logic [ipr_pkg::REG_W-1:0] prio_ff [ipr_pkg::NREG];
  logic nmi_prev_ff;
  logic nmi_pend_ff;
  logic [ipr_pkg::IRL_W-1:0] irl_prev_ff;
  logic [ipr_pkg::IRL_W-1:0] irl_ff;
  logic take;
  logic nmi_taken;
  logic [ipr_pkg::NSRC-1:0] req;
  logic [ipr_pkg::NSRC-1:0][ipr_pkg::LVL_W-1:0] lvl;
  logic win_valid;
  logic [ipr_pkg::SRC_W-1:0] win_idx;
  logic [ipr_pkg::LVL_W-1:0] win_level;
  logic [ipr_pkg::CODE_W-1:0] irl_code;

  // a request counts as accepted only while it is on offer
  // an acknowledge with nothing on offer is dropped here
  assign take = i_core_ack && cand_ff.req;
  assign nmi_taken = take && (cand_ff.src == ipr_pkg::SRC_W'(ipr_pkg::SRC_NMI));

  // ---------------------------------------------------------------
  // priority setting registers
  // ---------------------------------------------------------------
  // reset clears levels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int r = 0; r < ipr_pkg::NREG; r++) begin
        prio_ff[r] <= ipr_pkg::PRIO_RST;
      end
    end else if (i_prio_wr.en && (i_prio_wr.sel < ipr_pkg::RSEL_W'(ipr_pkg::NREG))) begin
      prio_ff[i_prio_wr.sel] <= i_prio_wr.data;
    end
  end

  // readback of the stored levels; unused selects read zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prio_rd_data <= '0;
    end else if (i_prio_rd_sel < ipr_pkg::RSEL_W'(ipr_pkg::NREG)) begin
      o_prio_rd_data <= prio_ff[i_prio_rd_sel];
    end else begin
      o_prio_rd_data <= '0;
    end
  end

  // ---------------------------------------------------------------
  // non-maskable input edge capture
  // ---------------------------------------------------------------
  // previous sample resets low like the idle pin, so reset makes no edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_prev_ff <= 1'b0;
    end else begin
      nmi_prev_ff <= nmi_s;
    end
  end

  // a fresh edge in the accept cycle stays pending: set beats clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_pend_ff <= 1'b0;
    end else if (nmi_s && !nmi_prev_ff) begin
      nmi_pend_ff <= 1'b1;
    end else if (nmi_taken) begin
      nmi_pend_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // encoded level inputs with noise filter
  // ---------------------------------------------------------------
  // new value taken only after two equal samples
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irl_prev_ff <= ipr_pkg::IRL_NONE;
      irl_ff <= ipr_pkg::IRL_NONE;
    end else begin
      irl_prev_ff <= irl_s;
      if (irl_s == irl_prev_ff) begin
        irl_ff <= irl_s;
      end
    end
  end

  assign irl_code = ipr_pkg::CODE_IRL_BASE
                  + ipr_pkg::CODE_W'({irl_ff, ipr_pkg::CODE_STEP_SHIFT'(0)});

  // ---------------------------------------------------------------
  // per-source request and level
  // ---------------------------------------------------------------
  for (genvar i = 0; i < ipr_pkg::NSRC; i++) begin : g_src
    if (i == ipr_pkg::SRC_NMI) begin : g_nmi
      assign req[i] = nmi_pend_ff;
      assign lvl[i] = ipr_pkg::LVL_NMI;
    end else if (i == ipr_pkg::SRC_DBG) begin : g_dbg
      assign req[i] = i_dbg_req;
      assign lvl[i] = ipr_pkg::LVL_DBG;
    end else if (i == ipr_pkg::SRC_IRL) begin : g_irl
      assign req[i] = (irl_ff != ipr_pkg::IRL_NONE);
      assign lvl[i] = ipr_pkg::LVL_W'(ipr_pkg::IRL_NONE - irl_ff);
    end else begin : g_prog
      logic [ipr_pkg::REG_W-1:0] reg_val;
      assign reg_val = prio_ff[ipr_pkg::SRC_REG[i]];
      assign lvl[i] = {1'b0, reg_val[ipr_pkg::SRC_FLD[i]*ipr_pkg::PRIO_W +: ipr_pkg::PRIO_W]};
      if (i < ipr_pkg::SRC_PORT_PIN_INTERRUPT_LO) begin : g_irq
        assign req[i] = irq_s[i-ipr_pkg::SRC_EXT_REQUEST_PIN_0];
      end else if (i == ipr_pkg::SRC_PORT_PIN_INTERRUPT_LO) begin : g_plo
        assign req[i] = |port_pin_interrupt_s[ipr_pkg::PORT_PIN_INTERRUPT_GRP-1:0];
      end else if (i == ipr_pkg::SRC_PORT_PIN_INTERRUPT_HI) begin : g_phi
        assign req[i] = |port_pin_interrupt_s[ipr_pkg::NPINT-1:ipr_pkg::PORT_PIN_INTERRUPT_GRP];
      end else begin : g_peri
        assign req[i] = i_periph[i-ipr_pkg::SRC_PERI0];
      end
    end
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  // index order is default order
  // sources sharing one field sit at neighbouring indices in listed order
  ipr_arb #(
    .N(ipr_pkg::NSRC)
  ) u_arb (
    .i_req(req),
    .i_level(lvl),
    .o_valid(win_valid),
    .o_idx(win_idx),
    .o_level(win_level)
  );

  // ---------------------------------------------------------------
  // offer state machine
  // ---------------------------------------------------------------
  // two quiet cycles after an accept let the taken source drop first
  // pin sources arrive two to four cycles late, so one just served can be
  // offered again; handlers must clear such a request at its source
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ipr_pkg::ST_IDLE: begin
        if (win_valid) begin
          nxt_state = ipr_pkg::ST_OFFER;
        end
      end
      ipr_pkg::ST_OFFER: begin
        if (take) begin
          nxt_state = ipr_pkg::ST_TAKEN;
        end else if (!win_valid) begin
          nxt_state = ipr_pkg::ST_IDLE;
        end
      end
      ipr_pkg::ST_TAKEN: begin
        nxt_state = ipr_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = ipr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ipr_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // presented candidate
  // ---------------------------------------------------------------
  // only the winner is offered
  always_comb begin
    nxt_cand = '0;
    if (nxt_state == ipr_pkg::ST_OFFER) begin
      nxt_cand.req = 1'b1;
      nxt_cand.level = win_level;
      nxt_cand.src = win_idx;
      nxt_cand.code = (win_idx == ipr_pkg::SRC_W'(ipr_pkg::SRC_IRL)) ?
                      irl_code : ipr_pkg::SRC_CODE[win_idx];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cand_ff <= '0;
    end else begin
      cand_ff <= nxt_cand;
    end
  end

  assign o_int_req = cand_ff.req;
  assign o_int_level = cand_ff.level;
  assign o_int_src = cand_ff.src;

  // ---------------------------------------------------------------
  // event code registers
  // ---------------------------------------------------------------
  // same code into both registers
  // code is the only source identity
  // no mask bit output at all
  // encoded source gets its level code in both registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_evt_a <= '0;
      o_evt_b <= '0;
    end else if (take) begin
      o_evt_a <= cand_ff.code;
      o_evt_b <= cand_ff.code;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accept <= 1'b0;
    end else begin
      o_accept <= take;
    end
  end

endmodule : ipr_top

/* File: test/ipr_core_model.sv */
// core-side model: accepts each offered request after a set wait
`timescale 1ns/1ns
module ipr_core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_int_req,
  input wire logic [3:0] i_wait,
  output logic o_ack
);
  logic [3:0] seen_ff;

  // cycles the current offer has stood; saturates so a long stall stays acked
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_ff <= 4'h0;
    end else if (!i_int_req) begin
      seen_ff <= 4'h0;
    end else if (seen_ff != 4'hf) begin
      seen_ff <= seen_ff + 4'h1;
    end
  end

  // ack pulses high for one cycle only, whether or not that edge takes it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
    end else begin
      o_ack <= i_int_req && !o_ack && (seen_ff >= i_wait);
    end
  end
endmodule : ipr_core_model

/* File: test/ipr_top_assertions.sv */
// port-level checker for the priority resolver
`timescale 1ns/1ns
module ipr_top_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_core_ack,
  input wire logic o_int_req,
  input wire logic [ipr_pkg::LVL_W-1:0] o_int_level,
  input wire logic [ipr_pkg::SRC_W-1:0] o_int_src,
  input wire logic [ipr_pkg::CODE_W-1:0] o_evt_a,
  input wire logic [ipr_pkg::CODE_W-1:0] o_evt_b,
  input wire logic o_accept
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_ACK_PULSE: assert property (
    o_int_req && i_core_ack |=> o_accept ##1 !o_accept) else $error("accept pulse wrong");
  AST_ACK_GAP: assert property (
    o_int_req && i_core_ack |=> !o_int_req [*2]) else $error("offer not withdrawn");
  AST_ACK_CAUSE: assert property (
    $rose(o_accept) |-> $past(o_int_req && i_core_ack)) else $error("accept without ack");
  AST_EVT_PAIR: assert property (
    o_evt_a == o_evt_b) else $error("event registers differ");
  AST_EVT_HOLD: assert property (
    !o_accept |-> o_evt_a == $past(o_evt_a)) else $error("event code moved");
  AST_LVL_RANGE: assert property (
    o_int_req |-> o_int_level inside {[1:16]}) else $error("offer at bad level");
  AST_NMI_LVL: assert property (
    o_int_req && o_int_src == 5'h00 |-> o_int_level == 5'h10) else $error("nmi level");
  AST_DBG_LVL: assert property (
    o_int_req && o_int_src == 5'h01 |-> o_int_level == 5'h0f) else $error("debug level");
  AST_CODE: assert property (
    o_int_req && i_core_ack && o_int_src != 5'h02
    |=> o_evt_a == ipr_pkg::SRC_CODE[$past(o_int_src)]) else $error("event code wrong");
  AST_IRL_CODE: assert property (
    o_int_req && i_core_ack && o_int_src == 5'h02
    |=> o_evt_a == 12'h3e0 - {2'h0, $past(o_int_level), 5'h00}) else $error("level code wrong");
endmodule : ipr_top_chk

bind ipr_top ipr_top_chk i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_core_ack(i_core_ack),
  .o_int_req(o_int_req), .o_int_level(o_int_level), .o_int_src(o_int_src),
  .o_evt_a(o_evt_a), .o_evt_b(o_evt_b), .o_accept(o_accept));

/* File: test/ipr_top_test.sv */
// self-checking bench for the priority resolver
`timescale 1ns/1ns
module ipr_top_test;
  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] bitn;
    logic [2:0] sel;
    logic [15:0] data;
    logic [4:0] lvl;
    logic [4:0] src;
    logic [11:0] code;
  } ipr_row_t;

  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_nmi = 1'b0;
  logic i_dbg_req = 1'b0;
  logic [3:0] i_irl_n = 4'hf;
  logic [5:0] i_irq = '0;
  logic [15:0] i_port_pin_interrupt = '0;
  logic [ipr_pkg::NPERI-1:0] i_periph = '0;
  ipr_pkg::ipr_prio_wr_t i_prio_wr = '0;
  logic [2:0] i_prio_rd_sel = 3'h0;
  logic [3:0] wait_n = 4'h0;
  logic i_core_ack;
  logic o_int_req;
  logic [4:0] o_int_level;
  logic [4:0] o_int_src;
  logic [11:0] o_evt_a;
  logic [11:0] o_evt_b;
  logic o_accept;
  logic [15:0] o_prio_rd_data;
  int err_count = 0;
  int n_checks = 0;

  // source kind, input bit, register, setting, expected level, source, code
  ipr_row_t rows [12] = '{
    '{2'h0, 5'h00, 3'h0, 16'h0001, 5'h01, 5'h03, 12'h600},
    '{2'h0, 5'h03, 3'h0, 16'hf000, 5'h0f, 5'h06, 12'h660},
    '{2'h0, 5'h05, 3'h1, 16'h0070, 5'h07, 5'h08, 12'h6a0},
    '{2'h1, 5'h03, 3'h1, 16'h9000, 5'h09, 5'h09, 12'h700},
    '{2'h1, 5'h0c, 3'h1, 16'h0a00, 5'h0a, 5'h0a, 12'h720},
    '{2'h2, 5'h00, 3'h2, 16'h2000, 5'h02, 5'h0b, 12'h800},
    '{2'h2, 5'h06, 3'h2, 16'h0300, 5'h03, 5'h11, 12'h8e0},
    '{2'h2, 5'h08, 3'h2, 16'h0040, 5'h04, 5'h13, 12'h920},
    '{2'h2, 5'h0a, 3'h2, 16'h0005, 5'h05, 5'h15, 12'h980},
    '{2'h2, 5'h0c, 3'h3, 16'h0060, 5'h06, 5'h17, 12'ha40},
    '{2'h2, 5'h0d, 3'h4, 16'h8000, 5'h08, 5'h18, 12'hc00},
    '{2'h2, 5'h10, 3'h5, 16'h0b00, 5'h0b, 5'h1b, 12'hca0}};

  always #5 i_clk = ~i_clk;

  ipr_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_nmi(i_nmi), .i_dbg_req(i_dbg_req),
    .i_irl_n(i_irl_n), .i_irq(i_irq), .i_port_pin_interrupt(i_port_pin_interrupt), .i_periph(i_periph),
    .i_prio_wr(i_prio_wr), .i_prio_rd_sel(i_prio_rd_sel), .i_core_ack(i_core_ack),
    .o_int_req(o_int_req), .o_int_level(o_int_level), .o_int_src(o_int_src),
    .o_evt_a(o_evt_a), .o_evt_b(o_evt_b), .o_accept(o_accept),
    .o_prio_rd_data(o_prio_rd_data));

  ipr_core_model i_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_int_req(o_int_req),
    .i_wait(wait_n), .o_ack(i_core_ack));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
    @(posedge i_clk);
    i_prio_rd_sel <= sel;
    repeat (2) @(posedge i_clk);
    #1 chk(o_prio_rd_data, exp);
  endtask : rd

  task automatic wr(input logic [2:0] sel, input logic [15:0] d, input logic [15:0] exp);
    @(posedge i_clk);
    i_prio_wr <= '{en: 1'b1, sel: sel, data: d};
    @(posedge i_clk);
    i_prio_wr.en <= 1'b0;
    rd(sel, exp);
  endtask : wr

  // called at a clock edge only
  task automatic clr();
    i_irq <= '0;
    i_port_pin_interrupt <= '0;
    i_periph <= '0;
    i_dbg_req <= 1'b0;
    i_nmi <= 1'b0;
    i_irl_n <= 4'hf;
  endtask : clr

  // first offer checked, then requests dropped on the accepting edge
  task automatic serve(input logic [4:0] lvl, input logic [4:0] src, input logic [11:0] code);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (o_int_req !== 1'b1 && n < 40);
    chk(16'(o_int_level), 16'(lvl));
    chk(16'(o_int_src), 16'(src));
    while (!(o_int_req === 1'b1 && i_core_ack === 1'b1) && n < 60) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk(16'(n < 60), 16'h0001);
    @(posedge i_clk);
    clr();
    #1 chk(16'(o_accept), 16'h0001);
    chk(16'(o_evt_a), 16'(code));
    chk(16'(o_evt_b), 16'(code));
    repeat (8) @(posedge i_clk);
  endtask : serve

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].sel, rows[k].data, rows[k].data);
      @(posedge i_clk);
      case (rows[k].kind)
        2'h0: i_irq[rows[k].bitn] <= 1'b1;
        2'h1: i_port_pin_interrupt[rows[k].bitn] <= 1'b1;
        default: i_periph[rows[k].bitn] <= 1'b1;
      endcase
      serve(rows[k].lvl, rows[k].src, rows[k].code);
    end
    wr(3'h2, 16'h3000, 16'h3000);
    wr(3'h3, 16'h0030, 16'h0030);
    @(posedge i_clk);
    i_periph <= 17'h0080a;
    serve(5'h03, 5'h0c, 12'h820);
    wr(3'h2, 16'hf000, 16'hf000);
    @(posedge i_clk);
    i_periph[0] <= 1'b1;
    i_dbg_req <= 1'b1;
    serve(5'h0f, 5'h01, 12'h5e0);
    for (int v = 0; v < 15; v += 7) begin
      @(posedge i_clk);
      // value zero asks for level fifteen
      i_irl_n <= 4'(v);
      serve(5'(15 - v), 5'h02, 12'h200 + 12'(v * 32));
    end
    @(posedge i_clk);
    wait_n <= 4'h6;
    i_nmi <= 1'b1;
    serve(5'h10, 5'h00, 12'h1c0);
    wr(3'h6, 16'hffff, 16'h0000);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // idle encoded pins give no request after reset
    for (int c = 0; c < 5; c++) begin
      @(posedge i_clk);
      #1 chk(16'({o_int_req, o_accept}), 16'h0000);
    end
    for (int s = 0; s < 6; s++) begin
      rd(3'(s), 16'h0000);
    end
    @(posedge i_clk);
    i_periph <= '1;
    i_irq <= '1;
    i_port_pin_interrupt <= '1;
    repeat (8) @(posedge i_clk);
    #1 chk(16'(o_int_req), 16'h0000);
    finish_test();
  end

  // run needs a few hundred cycles; hang cut at 30000 cycles, about eighty times that
  initial begin
    #300000;
    err_count++;
    finish_test();
  end
endmodule : ipr_top_test
